// ---- hdl/adt_pkg.sv ----
package adt_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int FAULT_FILTER_NS = 33000;
  localparam int FAULT_FILTER_CYC = (FAULT_FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 16;
  // dead-time defaults in cycles, chosen at integration
  localparam logic [CNT_W-1:0] FAILSAFE_CYC_DEF = 16'h0028;
  localparam logic [CNT_W-1:0] RISE_SETTLE_CYC_DEF = 16'h0004;
  localparam logic [CNT_W-1:0] FALL_SETTLE_CYC_DEF = 16'h0004;
  localparam logic [15:0] FAIL_COUNT_RST = 16'h0000;

  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ADT_IDLE = 5'h01,
    ADT_MAIN_ON = 5'h02,
    ADT_RISE_DT = 5'h04,
    ADT_CLAMP_ON = 5'h08,
    ADT_FALL_DT = 5'h10
  } adt_state_type;

  typedef enum logic [2:0] {
    ADT_F_RUN = 3'h1,
    ADT_F_LATCHED = 3'h2,
    ADT_F_WAIT = 3'h4
  } adt_fault_type;
endpackage

// ---- hdl/adt_timer_if.sv ----
`timescale 1ns/100ps
interface adt_timer_if;
  logic start;
  logic stop;
  logic [15:0] length;
  logic running;
  logic expired;
  modport owner (output start, output stop, output length,
    input running, input expired);
  modport timer (input start, input stop, input length,
    output running, output expired);
endinterface

// ---- hdl/adt_timer.sv ----
`timescale 1ns/100ps
module adt_timer (
  input wire logic clk_sys,
  input wire logic nrst,
  adt_timer_if.timer tif
);
  logic [15:0] count;

  // expired is a one-cycle pulse at terminal count; restart wins over stop
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      count <= 16'h0000;
      tif.running <= 1'b0;
      tif.expired <= 1'b0;
    end else begin
      tif.expired <= 1'b0;
      if (tif.start) begin
        count <= (tif.length == 16'h0000) ? 16'h0001 : tif.length;
        tif.running <= 1'b1;
      end else if (tif.stop) begin
        tif.running <= 1'b0;
      end else if (tif.running) begin
        if (count == 16'h0001) begin
          tif.running <= 1'b0;
          tif.expired <= 1'b1;
        end
        count <= count - 16'h0001;
      end
    end
  end
endmodule

// ---- hdl/adt_seq.sv ----
`timescale 1ns/100ps
// How it works
// RULE_01 - main drive falling starts the fail-safe dead-time timer
// RULE_02 - after main falls, first node-above-10V indication starts rise settle
// RULE_03 - rise settle expiry drives the clamp switch output high
// RULE_04 - fail-safe expiry before rise threshold counts a failure, no clamp; code still clamps if the node rises before the next cycle_start
// RULE_05 - clamp drive stays high until cycle end, then goes low
// RULE_06 - clamp drive falling restarts the fail-safe dead-time timer
// RULE_07 - after clamp falls, node at fall level starts fall settle timer
// RULE_08 - main drive rises on first of fall settle or fail-safe expiry
// RULE_09 - fail-safe timer ignored while clamp pulses phase in or out
// RULE_10 - fail-safe timer ignored during soft start phase-in
// RULE_11 - fault input above upper threshold faults: latch or restart
// RULE_12 - fault input below lower threshold is over-temperature fault
// RULE_13 - fault input between thresholds leaves switching untouched
// RULE_14 - low fault acted on only after persisting the filter time
// RULE_15 - latched fault holds off until supply reset
// RULE_16 - restart after over-temperature once input exceeds release level; code latches it instead when latch_option is set
// RULE_17 - all durations counted in clock cycles from integration constants; code takes dead-time and settle lengths from input ports
module adt_seq #(
  parameter int FILTER_CYC = adt_pkg::FAULT_FILTER_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic cycle_start,
  input wire logic cycle_end,
  input wire logic clamped_mode,
  input wire logic leading_edge_phasing,
  input wire logic softstart_phase_in,
  input wire logic bridge_node_above_rise,
  input wire logic bridge_node_at_fall_detect_level,
  input wire logic fault_above_upper,
  input wire logic fault_below_lower,
  input wire logic fault_above_release,
  input wire logic latch_option,
  input wire logic [15:0] failsafe_cycles,
  input wire logic [15:0] rise_settle_cycles,
  input wire logic [15:0] fall_settle_cycles,
  output logic main_switch_drive,
  output logic clamp_switch_drive,
  output logic [15:0] fail_count,
  output logic fault_active,
  output logic fault_latched,
  output logic soft_start_req
);
  // ---------------------------------------------------------------
  // timers
  // ---------------------------------------------------------------
  adt_timer_if fs_if ();
  adt_timer_if rs_if ();
  adt_timer_if fl_if ();

  adt_timer u_failsafe (.clk_sys(clk_sys), .nrst(nrst), .tif(fs_if));
  adt_timer u_rise (.clk_sys(clk_sys), .nrst(nrst), .tif(rs_if));
  adt_timer u_fall (.clk_sys(clk_sys), .nrst(nrst), .tif(fl_if));

  adt_pkg::adt_state_type state;
  // ---------------------------------------------------------------
  // state declarations
  // ---------------------------------------------------------------
  adt_pkg::adt_state_type next_state;
  adt_pkg::adt_fault_type fstate;
  logic rise_seen;
  logic fall_seen;
  logic failsafe_used;
  logic run_ok;
  logic [31:0] low_cnt;
  logic [31:0] high_cnt;
  logic low_qual;
  logic high_qual;

  // fail-safe only honoured in full clamped operation
  assign failsafe_used = clamped_mode && !leading_edge_phasing
    && !softstart_phase_in; // RULE_09 RULE_10
  assign run_ok = (fstate == adt_pkg::ADT_F_RUN) && !low_qual
    && !high_qual; // RULE_13

  assign fs_if.length = failsafe_cycles; // RULE_17
  assign rs_if.length = rise_settle_cycles;
  assign fl_if.length = fall_settle_cycles;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    fs_if.start = 1'b0;
    fs_if.stop = 1'b0;
    rs_if.start = 1'b0;
    rs_if.stop = 1'b0;
    fl_if.start = 1'b0;
    fl_if.stop = 1'b0;
    if (!run_ok) begin
      next_state = adt_pkg::ADT_IDLE;
      fs_if.stop = 1'b1;
      rs_if.stop = 1'b1;
      fl_if.stop = 1'b1;
    end else begin
      unique case (state)
        adt_pkg::ADT_IDLE: begin
          if (cycle_start) begin
            next_state = adt_pkg::ADT_MAIN_ON;
          end
        end
        adt_pkg::ADT_MAIN_ON: begin
          if (cycle_end) begin
            next_state = adt_pkg::ADT_RISE_DT;
            fs_if.start = 1'b1; // RULE_01
          end
        end
        adt_pkg::ADT_RISE_DT: begin
          if (bridge_node_above_rise && !rise_seen && !rs_if.running) begin
            rs_if.start = 1'b1; // RULE_02
          end
          if (rs_if.expired) begin
            next_state = adt_pkg::ADT_CLAMP_ON; // RULE_03
            fs_if.stop = 1'b1;
          end else if (cycle_start) begin
            // clamp never forced: cycle moves on without it
            next_state = adt_pkg::ADT_MAIN_ON; // RULE_04
            fs_if.stop = 1'b1;
            rs_if.stop = 1'b1;
          end
        end
        adt_pkg::ADT_CLAMP_ON: begin
          if (cycle_start) begin
            next_state = adt_pkg::ADT_FALL_DT; // RULE_05
            fs_if.start = 1'b1; // RULE_06
          end
        end
        adt_pkg::ADT_FALL_DT: begin
          if (bridge_node_at_fall_detect_level && !fall_seen
              && !fl_if.running) begin
            fl_if.start = 1'b1; // RULE_07
          end
          if (fl_if.expired || (fs_if.expired && failsafe_used)) begin
            next_state = adt_pkg::ADT_MAIN_ON; // RULE_08
            fs_if.stop = 1'b1;
            fl_if.stop = 1'b1;
          end
        end
        default: begin
          next_state = adt_pkg::ADT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= adt_pkg::ADT_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // first indication only, per edge
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rise_seen <= 1'b0;
      fall_seen <= 1'b0;
    end else begin
      if (fs_if.start && next_state == adt_pkg::ADT_RISE_DT) begin
        rise_seen <= 1'b0;
      end else if (rs_if.start) begin
        rise_seen <= 1'b1;
      end
      if (fs_if.start && next_state == adt_pkg::ADT_FALL_DT) begin
        fall_seen <= 1'b0;
      end else if (fl_if.start) begin
        fall_seen <= 1'b1;
      end
    end
  end

  // drives come straight from flops
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      main_switch_drive <= 1'b0;
      clamp_switch_drive <= 1'b0;
    end else begin
      main_switch_drive <= (next_state == adt_pkg::ADT_MAIN_ON);
      clamp_switch_drive <= (next_state == adt_pkg::ADT_CLAMP_ON);
    end
  end

  // failure counter saturates rather than wrapping
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fail_count <= adt_pkg::FAIL_COUNT_RST;
    end else if (state == adt_pkg::ADT_RISE_DT && fs_if.expired
        && failsafe_used && !rise_seen && !rs_if.expired
        && fail_count != 16'hFFFF) begin
      fail_count <= fail_count + 16'h0001; // RULE_04
    end
  end

  // ---------------------------------------------------------------
  // fault input qualification
  // ---------------------------------------------------------------
  // a single glitch-free stretch is needed; any break restarts the count
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      low_cnt <= 32'h00000000;
      low_qual <= 1'b0;
    end else if (!fault_below_lower) begin
      low_cnt <= 32'h00000000;
      low_qual <= 1'b0;
    end else if (low_cnt < 32'(FILTER_CYC)) begin
      low_cnt <= low_cnt + 32'h00000001;
    end else begin
      low_qual <= 1'b1; // RULE_14 RULE_12
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      high_cnt <= 32'h00000000;
      high_qual <= 1'b0;
    end else if (!fault_above_upper) begin
      high_cnt <= 32'h00000000;
      high_qual <= 1'b0;
    end else if (high_cnt < 32'(FILTER_CYC)) begin
      high_cnt <= high_cnt + 32'h00000001;
    end else begin
      high_qual <= 1'b1; // RULE_11
    end
  end

  // ---------------------------------------------------------------
  // fault reaction
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fstate <= adt_pkg::ADT_F_RUN; // RULE_15
      soft_start_req <= 1'b0;
    end else begin
      soft_start_req <= 1'b0;
      unique case (fstate)
        adt_pkg::ADT_F_RUN: begin
          if (low_qual || high_qual) begin
            fstate <= latch_option ? adt_pkg::ADT_F_LATCHED
              : adt_pkg::ADT_F_WAIT; // RULE_11 RULE_12
          end
        end
        adt_pkg::ADT_F_LATCHED: begin
          fstate <= adt_pkg::ADT_F_LATCHED; // RULE_15
        end
        adt_pkg::ADT_F_WAIT: begin
          if (fault_above_release && !fault_below_lower
              && !fault_above_upper) begin
            fstate <= adt_pkg::ADT_F_RUN; // RULE_16
            soft_start_req <= 1'b1;
          end
        end
        default: begin
          fstate <= adt_pkg::ADT_F_LATCHED;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fault_active <= 1'b0;
      fault_latched <= 1'b0;
    end else begin
      fault_active <= (fstate != adt_pkg::ADT_F_RUN) || low_qual
        || high_qual;
      fault_latched <= (fstate == adt_pkg::ADT_F_LATCHED);
    end
  end
endmodule

// ---- testbench/adt_seq_sva.sv ----
`timescale 1ns/100ps
// ---------------------------
// sequencer checks
// ---------------------------
module adt_seq_sva #(
  parameter int FILTER_CYC = 8
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic cycle_start,
  input wire logic bridge_node_above_rise,
  input wire logic fault_above_upper,
  input wire logic fault_below_lower,
  input wire logic main_switch_drive,
  input wire logic clamp_switch_drive,
  input wire logic [15:0] fail_count,
  input wire logic fault_active,
  input wire logic fault_latched,
  input wire logic soft_start_req
);
  logic [15:0] low_run;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // length of the current low excursion
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst)
      low_run <= 16'h0000;
    else if (fault_below_lower)
      low_run <= low_run + 16'h0001;
    else
      low_run <= 16'h0000;
  end
  no_overlap_a: assert property (
    !(main_switch_drive && clamp_switch_drive)) else $error("overlap");
  clamp_after_node_a: assert property (
    $rose(clamp_switch_drive) |-> $past(bridge_node_above_rise, 2))
    else $error("clamp before node");
  clamp_end_a: assert property (
    $fell(clamp_switch_drive) && !fault_active && !fault_latched
    |-> $past(cycle_start)) else $error("clamp fell early");
  main_gap_a: assert property (
    $rose(main_switch_drive) |-> !$past(clamp_switch_drive, 2))
    else $error("main too soon");
  fault_off_a: assert property (
    $rose(fault_active) |=> !main_switch_drive && !clamp_switch_drive)
    else $error("drive during fault");
  latch_hold_a: assert property (
    fault_latched |=> fault_latched && !main_switch_drive)
    else $error("latch lost");
  fail_step_a: assert property (
    $changed(fail_count) |-> fail_count == $past(fail_count) + 16'h0001)
    else $error("failure count jump");
  filter_time_a: assert property (
    $rose(fault_active) && !$past(fault_above_upper)
    |-> low_run >= FILTER_CYC - 1) else $error("filter short");
  cover property ($rose(clamp_switch_drive));
  cover property ($changed(fail_count));
  cover property (soft_start_req);
endmodule
bind adt_seq adt_seq_sva #(.FILTER_CYC(FILTER_CYC)) adt_seq_sva_inst (
  .clk_sys, .nrst, .cycle_start, .bridge_node_above_rise,
  .fault_above_upper, .fault_below_lower, .main_switch_drive,
  .clamp_switch_drive, .fail_count, .fault_active, .fault_latched,
  .soft_start_req);

// ---- testbench/adt_power_stage.sv ----
`timescale 1ns/100ps
module adt_power_stage (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic main_switch_drive,
  input wire logic clamp_switch_drive,
  input wire logic [3:0] rise_delay,
  input wire logic [3:0] fall_delay,
  input wire logic stuck,
  output logic bridge_node_above_rise,
  output logic bridge_node_at_fall_detect_level
);
  logic main_q, clamp_q, rising, falling, node_high;
  logic [3:0] cnt;
  assign bridge_node_above_rise = node_high;
  assign bridge_node_at_fall_detect_level = !node_high;
  // stuck models too little current to lift the node
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      {main_q, clamp_q, rising, falling, node_high} <= 5'h00;
      cnt <= 4'h0;
    end else begin
      main_q <= main_switch_drive;
      clamp_q <= clamp_switch_drive;
      if (main_q && !main_switch_drive && !stuck)
        rising <= 1'b1;
      if (clamp_q && !clamp_switch_drive)
        falling <= 1'b1;
      if (rising || falling)
        cnt <= cnt + 4'h1;
      if (rising && cnt == rise_delay) begin
        node_high <= 1'b1;
        rising <= 1'b0;
        cnt <= 4'h0;
      end
      if (falling && cnt == fall_delay) begin
        node_high <= 1'b0;
        falling <= 1'b0;
        cnt <= 4'h0;
      end
    end
  end
endmodule

// ---- testbench/adt_seq_bench.sv ----
`timescale 1ns/100ps
module adt_seq_bench;
  logic clk_sys, nrst, cycle_start, cycle_end, clamped_mode, stuck;
  logic leading_edge_phasing, softstart_phase_in, latch_option;
  logic bridge_node_above_rise, bridge_node_at_fall_detect_level;
  logic fault_above_upper, fault_below_lower, fault_above_release;
  logic main_switch_drive, clamp_switch_drive, fault_active;
  logic fault_latched, soft_start_req;
  logic [15:0] failsafe_cycles, rise_settle_cycles, fall_settle_cycles;
  logic [15:0] fail_count;
  logic [3:0] rise_delay, fall_delay;
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;
  adt_seq #(.FILTER_CYC(8)) adt_seq_inst (.clk_sys, .nrst, .cycle_start,
    .cycle_end, .clamped_mode, .leading_edge_phasing, .softstart_phase_in,
    .bridge_node_above_rise, .bridge_node_at_fall_detect_level,
    .fault_above_upper, .fault_below_lower, .fault_above_release,
    .latch_option, .failsafe_cycles, .rise_settle_cycles,
    .fall_settle_cycles, .main_switch_drive, .clamp_switch_drive,
    .fail_count, .fault_active, .fault_latched, .soft_start_req);
  adt_power_stage adt_power_stage_inst (.clk_sys, .nrst,
    .main_switch_drive, .clamp_switch_drive, .rise_delay, .fall_delay,
    .stuck, .bridge_node_above_rise, .bridge_node_at_fall_detect_level);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      tally_and_finish;
    end
  end
  task automatic check(input string nm, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tally_and_finish;
    if (err_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task pulse(input bit start);
    @(posedge clk_sys);
    if (start)
      cycle_start <= 1'b1;
    else
      cycle_end <= 1'b1;
    @(posedge clk_sys);
    cycle_start <= 1'b0;
    cycle_end <= 1'b0;
  endtask
  // sampled 1 ns after the edge so register updates have landed
  task automatic wait_lv(ref logic s, input logic v, input int lim);
    #1;
    for (int i = 0; i < lim && s !== v; i++) begin
      @(posedge clk_sys);
      #1;
    end
  endtask
  task do_reset;
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
  endtask
  task run_cycle(input logic exp_clamp, input logic [15:0] exp_fail);
    wait_lv(main_switch_drive, 1'b1, 60);
    check("main on", 16'(main_switch_drive), 16'h0001);
    repeat (3) @(posedge clk_sys);
    pulse(1'b0);
    wait_lv(clamp_switch_drive, 1'b1, 40);
    check("clamp on", 16'(clamp_switch_drive), 16'(exp_clamp));
    check("failures", fail_count, exp_fail);
    pulse(1'b1);
    wait_lv(clamp_switch_drive, 1'b0, 4);
    check("clamp off", 16'(clamp_switch_drive), 16'h0000);
  endtask
  initial begin
    {nrst, cycle_start, cycle_end, stuck, leading_edge_phasing} = 5'h00;
    {softstart_phase_in, fault_above_upper, fault_below_lower} = 3'h0;
    {clamped_mode, fault_above_release, latch_option} = 3'h6;
    failsafe_cycles = 16'h0014;
    rise_settle_cycles = 16'h0002;
    fall_settle_cycles = 16'h0002;
    rise_delay = 4'h2;
    fall_delay = 4'h2;
    void'($urandom(43306));
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    pulse(1'b1);
    for (int k = 0; k < 6; k++) begin
      rise_delay <= 4'($urandom_range(1, 7));
      fall_delay <= 4'($urandom_range(1, 7));
      fall_settle_cycles <= 16'($urandom_range(1, 8));
      rise_settle_cycles <= (k == 0) ? 16'h0001 : 16'($urandom_range(1, 8));
      run_cycle(1'b1, 16'h0000);
    end
    // node never rises: full mode, phasing, soft start phase-in
    for (int m = 0; m < 3; m++) begin
      do_reset;
      stuck <= 1'b1;
      leading_edge_phasing <= (m == 1);
      softstart_phase_in <= (m == 2);
      pulse(1'b1);
      run_cycle(1'b0, (m == 0) ? 16'h0001 : 16'h0000);
    end
    do_reset;
    {stuck, leading_edge_phasing, softstart_phase_in} <= 3'h0;
    {fault_below_lower, fault_above_release} <= 2'h2;
    repeat (6) @(posedge clk_sys);
    {fault_below_lower, fault_above_release} <= 2'h1;
    wait_lv(fault_active, 1'b1, 4);
    check("glitch", 16'(fault_active), 16'h0000);
    {fault_below_lower, fault_above_release} <= 2'h2;
    wait_lv(fault_active, 1'b1, 14);
    check("low fault", 16'(fault_active), 16'h0001);
    check("main held", 16'(main_switch_drive), 16'h0000);
    {fault_below_lower, fault_above_release} <= 2'h1;
    wait_lv(soft_start_req, 1'b1, 20);
    check("restart", 16'(soft_start_req), 16'h0001);
    latch_option <= 1'b1;
    fault_above_upper <= 1'b1;
    wait_lv(fault_latched, 1'b1, 40);
    check("latched", 16'(fault_latched), 16'h0001);
    fault_above_upper <= 1'b0;
    pulse(1'b1);
    wait_lv(main_switch_drive, 1'b1, 6);
    check("stays off", 16'(main_switch_drive), 16'h0000);
    do_reset;
    wait_lv(fault_latched, 1'b0, 2);
    check("unlatched", 16'(fault_latched), 16'h0000);
    tally_and_finish;
  end
endmodule
